// >>> hdl/adc_config_and_result_ctrl.sv
// Control logic around a 10-bit sampling converter: registers, clock select, completion
//
// Overview of operation
// - Align-select one right-aligns, high six bits zero
// - Align-select zero left-aligns, low six bits zero
// - Clock select three bits: divide or RC
// - Second-register bits five and four read zero
// - Port code decodes pins analog or digital
// - Port code picks reference sources per table
// - Channel and reference counts match table
// - Reset forces multiplexed pins to analog
// - Completion loads result, clears go, sets flag
// - Go while powered starts, clears when done
// - Three-bit field selects one of eight channels
// - Power bit zero shuts converter off
// - Clearing go aborts, result kept
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`include "adc_ctrl_defs.svh"
module adc_config_and_result_ctrl (
  input wire logic ref_clk, // Device clock, 20 MHz
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  output logic irq, // Interrupt level
  output logic conv_power_on, // Core powered
  output logic [2:0] channel_select, // Channel to sample
  output logic [7:0] pin_analog, // Per-pin analog assignment
  output logic vref_pos_pin, // Positive reference from pin three
  output logic vref_neg_pin, // Negative reference from pin two
  output logic [3:0] analog_count, // Analog channel count
  output logic [1:0] vref_count, // Reference pin count
  output logic conv_clk_tick, // One pulse per bit period
  output logic sample_start, // Pulse: core starts conversion
  input wire logic [9:0] core_result // Result from core, valid at completion
);
  adc_ctrl_pkg::reg_req_t req;
  adc_ctrl_pkg::port_map_t pmap;
  adc_ctrl_pkg::conv_state_t st_q, st_d;
  logic [7:0] ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d, resh_q, resh_d, resl_q, resl_d;
  logic [7:0] rdata_d;
  logic done_flag_q, done_flag_d, irq_en_q, irq_en_d;
  logic [6:0] div_q, div_d;
  logic [6:0] div_lim;
  logic tick_d, tick_q, start_d, start_q;
  logic [3:0] per_q, per_d;
  logic [3:0] cnt_d;
  logic [1:0] vcnt_d;

  // Divider reload from the three select bits
  function automatic logic [6:0] clk_limit(input logic hi, input logic [1:0] lo);
    logic [6:0] l;
    l = 7'h00;
    case ({hi, lo})
      3'b000: l = 7'h01;
      3'b001: l = 7'h07;
      3'b010: l = 7'h1f;
      3'b100: l = 7'h03;
      3'b101: l = 7'h0f;
      3'b110: l = 7'h3f;
      default: l = 7'(`RC_DIV - 1);
    endcase
    return l;
  endfunction

  function automatic adc_ctrl_pkg::port_map_t port_decode(input logic [3:0] c);
    adc_ctrl_pkg::port_map_t m;
    m = '0;
    case (c)
      4'h0: m = {8'hff, 1'b0, 1'b0};
      4'h1: m = {8'hf7, 1'b1, 1'b0};
      4'h2: m = {8'h1f, 1'b0, 1'b0};
      4'h3: m = {8'h17, 1'b1, 1'b0};
      4'h4: m = {8'h0b, 1'b0, 1'b0};
      4'h5: m = {8'h03, 1'b1, 1'b0};
      4'h6, 4'h7: m = {8'h00, 1'b0, 1'b0};
      4'h8: m = {8'hf3, 1'b1, 1'b1};
      4'h9: m = {8'h3f, 1'b0, 1'b0};
      4'ha: m = {8'h37, 1'b1, 1'b0};
      4'hb: m = {8'h33, 1'b1, 1'b1};
      4'hc: m = {8'h13, 1'b1, 1'b1};
      4'hd: m = {8'h03, 1'b1, 1'b1};
      4'he: m = {8'h01, 1'b0, 1'b0};
      default: m = {8'h01, 1'b1, 1'b1};
    endcase
    return m;
  endfunction

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  always_comb begin
    pmap = port_decode(ctrl2_q[3:0]);
    cnt_d = 4'h0;
    for (int i = 0; i < 8; i++) begin
      cnt_d = cnt_d + 4'(pmap.pin_analog[i]);
    end
    vcnt_d = 2'(pmap.vref_pos_pin) + 2'(pmap.vref_neg_pin);
    div_lim = clk_limit(ctrl2_q[`BIT_CLK_HI], ctrl1_q[7:6]);
  end

  // Converter sequencing and register writes
  always_comb begin
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    resh_d = resh_q;
    resl_d = resl_q;
    done_flag_d = done_flag_q;
    irq_en_d = irq_en_q;
    st_d = st_q;
    per_d = per_q;
    start_d = 1'b0;
    div_d = div_q;
    tick_d = 1'b0;
    if (st_q == adc_ctrl_pkg::ST_IDLE || div_q == 7'h00) begin
      div_d = div_lim;
      tick_d = (st_q != adc_ctrl_pkg::ST_IDLE);
    end else begin
      div_d = div_q - 7'h01;
    end
    if (req.wr) begin
      case (req.addr)
        `OFS_CTRL_FIRST: ctrl1_d = req.wdata & `CTRL_FIRST_WMASK;
        `OFS_CTRL_SECOND: ctrl2_d = req.wdata & `CTRL_SECOND_WMASK;
        `OFS_RESULT_HIGH: resh_d = req.wdata;
        `OFS_RESULT_LOW: resl_d = req.wdata;
        `OFS_IRQ_ENABLE: irq_en_d = req.wdata[0];
        `OFS_IRQ_CLEAR: if (req.wdata[0]) done_flag_d = 1'b0;
        default: ;
      endcase
    end
    case (st_q)
      adc_ctrl_pkg::ST_IDLE: begin
        if (ctrl1_q[`BIT_GO] && ctrl1_q[`BIT_POWER]) begin
          st_d = adc_ctrl_pkg::ST_WAIT;
          start_d = 1'b1;
        end
      end
      adc_ctrl_pkg::ST_WAIT, adc_ctrl_pkg::ST_CONV: begin
        if (!ctrl1_q[`BIT_GO] || !ctrl1_q[`BIT_POWER]) begin
          st_d = adc_ctrl_pkg::ST_IDLE;
        end else if (tick_d) begin
          if (st_q == adc_ctrl_pkg::ST_WAIT) begin
            st_d = adc_ctrl_pkg::ST_CONV;
            per_d = 4'h0;
          end else if (per_q == `CONV_PERIODS - 4'h1) begin
            st_d = adc_ctrl_pkg::ST_IDLE;
            ctrl1_d[`BIT_GO] = 1'b0;
            done_flag_d = 1'b1;
            if (ctrl2_q[`BIT_ALIGN]) begin
              resh_d = {6'h00, core_result[9:8]};
              resl_d = core_result[7:0];
            end else begin
              resh_d = core_result[9:2];
              resl_d = {core_result[1:0], 6'h00};
            end
          end else begin
            per_d = per_q + 4'h1;
          end
        end
      end
      default: st_d = adc_ctrl_pkg::ST_IDLE;
    endcase
  end

  always_comb begin
    rdata_d = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `OFS_CTRL_FIRST: rdata_d = ctrl1_q;
        `OFS_CTRL_SECOND: rdata_d = ctrl2_q;
        `OFS_RESULT_HIGH: rdata_d = resh_q;
        `OFS_RESULT_LOW: rdata_d = resl_q;
        `OFS_IRQ_STATUS: rdata_d = {7'h00, done_flag_q};
        `OFS_IRQ_ENABLE: rdata_d = {7'h00, irq_en_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl1_q <= `CTRL_FIRST_RESET;
      ctrl2_q <= `CTRL_SECOND_RESET;
      resh_q <= 8'h00;
      resl_q <= 8'h00;
      done_flag_q <= 1'b0;
      irq_en_q <= 1'b0;
      st_q <= adc_ctrl_pkg::ST_IDLE;
      per_q <= 4'h0;
      div_q <= 7'h00;
      tick_q <= 1'b0;
      start_q <= 1'b0;
      reg_rdata <= 8'h00;
      irq <= 1'b0;
      conv_power_on <= 1'b0;
      channel_select <= 3'h0;
      pin_analog <= 8'hff;
      vref_pos_pin <= 1'b0;
      vref_neg_pin <= 1'b0;
      analog_count <= 4'h8;
      vref_count <= 2'h0;
    end else begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      resh_q <= resh_d;
      resl_q <= resl_d;
      done_flag_q <= done_flag_d;
      irq_en_q <= irq_en_d;
      st_q <= st_d;
      per_q <= per_d;
      div_q <= div_d;
      tick_q <= tick_d;
      start_q <= start_d;
      reg_rdata <= rdata_d;
      irq <= done_flag_d & irq_en_d;
      conv_power_on <= ctrl1_d[`BIT_POWER];
      channel_select <= ctrl1_d[5:3];
      pin_analog <= pmap.pin_analog;
      vref_pos_pin <= pmap.vref_pos_pin;
      vref_neg_pin <= pmap.vref_neg_pin;
      analog_count <= cnt_d;
      vref_count <= vcnt_d;
    end
  end
  assign conv_clk_tick = tick_q;
  assign sample_start = start_q;

  property p_right_align;
    @(posedge ref_clk) disable iff (!resetn)
      (st_q == adc_ctrl_pkg::ST_CONV && st_d == adc_ctrl_pkg::ST_IDLE && ctrl1_q[`BIT_GO]
        && ctrl1_q[`BIT_POWER] && ctrl2_q[7])
      |=> resh_q[7:2] == 6'h00;
  endproperty
  a_right_align: assert property (p_right_align) else $error("right align high bits not zero");
  property p_left_align;
    @(posedge ref_clk) disable iff (!resetn)
      (st_q == adc_ctrl_pkg::ST_CONV && st_d == adc_ctrl_pkg::ST_IDLE && ctrl1_q[`BIT_GO]
        && ctrl1_q[`BIT_POWER] && !ctrl2_q[7])
      |=> resl_q[5:0] == 6'h00;
  endproperty
  a_left_align: assert property (p_left_align) else $error("left align low bits not zero");
  property p_unimpl;
    @(posedge ref_clk) disable iff (!resetn) (req.rd && req.addr == `OFS_CTRL_SECOND) |=> reg_rdata[5:4] == 2'b00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits read nonzero");
  property p_all_digital;
    @(posedge ref_clk) disable iff (!resetn) (ctrl2_q[3:1] == 3'b011) |=> pin_analog == 8'h00;
  endproperty
  a_all_digital: assert property (p_all_digital) else $error("code 011x not all digital");
  property p_counts;
    @(posedge ref_clk) disable iff (!resetn)
      ##1 (vref_count == 2'(vref_pos_pin) + 2'(vref_neg_pin) && analog_count == 4'($countones(pin_analog)));
  endproperty
  a_counts: assert property (p_counts) else $error("reference count mismatch");
  sequence s_done;
    // Power loss also leaves the conversion state, but is an abort, not a completion
    st_q == adc_ctrl_pkg::ST_CONV && st_d == adc_ctrl_pkg::ST_IDLE && ctrl1_q[`BIT_GO] && ctrl1_q[`BIT_POWER];
  endsequence
  property p_done;
    @(posedge ref_clk) disable iff (!resetn) s_done |=> (!ctrl1_q[`BIT_GO] && done_flag_q);
  endproperty
  a_done: assert property (p_done) else $error("completion did not clear go or set flag");
  property p_start;
    @(posedge ref_clk) disable iff (!resetn)
      (st_q == adc_ctrl_pkg::ST_IDLE && ctrl1_q[`BIT_GO] && ctrl1_q[`BIT_POWER]) |=> sample_start;
  endproperty
  a_start: assert property (p_start) else $error("go did not start conversion");
  property p_abort;
    @(posedge ref_clk) disable iff (!resetn)
      (st_q != adc_ctrl_pkg::ST_IDLE && !ctrl1_q[`BIT_GO]) |=> (st_q == adc_ctrl_pkg::ST_IDLE && $stable(resh_q));
  endproperty
  a_abort: assert property (p_abort) else $error("abort changed result");
endmodule

// >>> inc/adc_ctrl_defs.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH
`define OFS_RESULT_HIGH 8'h1e
`define OFS_CTRL_FIRST 8'h1f
`define OFS_RESULT_LOW 8'h9e
`define OFS_CTRL_SECOND 8'h9f
`define OFS_IRQ_STATUS 8'ha0
`define OFS_IRQ_ENABLE 8'ha1
`define OFS_IRQ_CLEAR 8'ha2
`define CTRL_FIRST_RESET 8'h00
`define CTRL_SECOND_RESET 8'h00
`define CTRL_FIRST_WMASK 8'hfd
`define CTRL_SECOND_WMASK 8'hcf
`define BIT_GO 2
`define BIT_POWER 0
`define BIT_ALIGN 7
`define BIT_CLK_HI 6
`define CONV_PERIODS 4'hc
`define RC_PERIOD_NS 4000
`define CLK_PERIOD_NS 50
`define RC_DIV (`RC_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// >>> inc/adc_ctrl_pkg.sv
// Types shared by the converter control
package adc_ctrl_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} conv_state_t;
  typedef struct packed {
    logic [7:0] pin_analog;
    logic vref_pos_pin;
    logic vref_neg_pin;
  } port_map_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// >>> tb/adc_core_model.sv
// Behavioural converter core: result follows the selected channel
`timescale 1ns/10ps
module adc_core_model (
  input wire logic ref_clk, // Device clock
  input wire logic sample_start, // Conversion start pulse
  input wire logic conv_power_on, // Core powered
  input wire logic [2:0] channel_select, // Channel sampled
  output logic [9:0] core_result // Result to control logic
);
  logic [9:0] held_q = 10'h000;
  always @(posedge ref_clk) begin
    if (sample_start) begin
      // Channel pins are only sampled, never driven, so they stay inputs
      held_q <= {7'h5a, channel_select};
    end
  end
  // Unpowered core gives no valid value, so show the inverse
  assign core_result = conv_power_on ? held_q : ~held_q;
endmodule

// >>> tb/adc_config_and_result_ctrl_tb.sv
// Self-checking bench for the converter control
`timescale 1ns/10ps
`include "adc_ctrl_defs.svh"
module adc_config_and_result_ctrl_tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, irq, conv_power_on, vref_pos_pin, vref_neg_pin, conv_clk_tick, sample_start;
  logic [2:0] channel_select;
  logic [7:0] pin_analog, d;
  logic [3:0] analog_count;
  logic [1:0] vref_count;
  logic [9:0] core_result;
  logic [7:0] prev_hi, prev_lo;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  logic [15:0] dec_tab [16] = '{16'hff20, 16'hf79d, 16'h1f14, 16'h1791, 16'h0b0c, 16'h0389, 16'h0000, 16'h0000,
    16'hf3da, 16'h3f18, 16'h3795, 16'h33d2, 16'h13ce, 16'h03ca, 16'h0104, 16'h01c6};
  int div_tab [8] = '{2, 8, 32, 80, 4, 16, 64, 80};
  localparam int acq_wait = 400; // About 20 us of acquisition
  always #25 ref_clk = ~ref_clk;
  adc_config_and_result_ctrl i_adc_config_and_result_ctrl (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .conv_power_on(conv_power_on), .channel_select(channel_select), .pin_analog(pin_analog),
    .vref_pos_pin(vref_pos_pin), .vref_neg_pin(vref_neg_pin), .analog_count(analog_count), .vref_count(vref_count),
    .conv_clk_tick(conv_clk_tick), .sample_start(sample_start), .core_result(core_result));
  adc_core_model i_adc_core_model (.ref_clk(ref_clk), .sample_start(sample_start), .conv_power_on(conv_power_on),
    .channel_select(channel_select), .core_result(core_result));
  task automatic test_done;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask
  task automatic regs_and_decode;
    chk("reset map", 16'hff20, {pin_analog, vref_pos_pin, vref_neg_pin, analog_count, vref_count});
    wr(`OFS_CTRL_SECOND, 8'hff);
    rd(`OFS_CTRL_SECOND, d);
    chk("ctrl second", 16'h00cf, {8'h00, d});
    rd(8'h55, d);
    chk("unmapped", 16'h0000, {8'h00, d});
    for (int c = 0; c < 16; c++) begin
      wr(`OFS_CTRL_SECOND, {4'h0, c[3:0]});
      // Pin map is registered one edge after the code
      repeat (2) @(negedge ref_clk);
      chk("port map", dec_tab[c], {pin_analog, vref_pos_pin, vref_neg_pin, analog_count, vref_count});
    end
  endtask
  task automatic conv(input int i);
    logic [9:0] r;
    logic [7:0] hi;
    int n;
    r = {7'h5a, i[2:0]};
    wr(`OFS_CTRL_SECOND, {i[0], i[2], 6'h00});
    wr(`OFS_CTRL_FIRST, {i[1:0], i[2:0], 3'b001});
    wr(`OFS_IRQ_CLEAR, 8'h01);
    wr(`OFS_IRQ_ENABLE, {7'h00, i != 0});
    repeat (acq_wait) @(posedge ref_clk);
    wr(`OFS_CTRL_FIRST, {i[1:0], i[2:0], 3'b101});
    repeat (2) @(negedge ref_clk);
    chk("start pulse", 16'h0001, 16'(sample_start));
    for (n = 0; n < 200 && conv_clk_tick !== 1'b1; n++) @(negedge ref_clk);
    for (n = 1; n < 200; n++) begin
      @(negedge ref_clk);
      if (conv_clk_tick === 1'b1) break;
    end
    chk("tick period", 16'(div_tab[i]), 16'(n));
    chk("channel", 16'(i[2:0]), 16'(channel_select));
    chk("power", 16'h0001, 16'(conv_power_on));
    d = 8'h04;
    for (n = 0; n < 1500 && d[`BIT_GO] !== 1'b0; n++) rd(`OFS_CTRL_FIRST, d);
    chk("go cleared", 16'h0000, 16'(d[`BIT_GO]));
    rd(`OFS_RESULT_HIGH, hi);
    rd(`OFS_RESULT_LOW, d);
    chk("result", i[0] ? {6'h00, r} : {r, 6'h00}, {hi, d});
    prev_hi = hi;
    prev_lo = d;
    rd(`OFS_IRQ_STATUS, d);
    chk("done flag", 16'h0001, 16'(d));
    chk("irq", 16'(i != 0), 16'(irq));
    wr(`OFS_IRQ_CLEAR, 8'h01);
    rd(`OFS_IRQ_STATUS, d);
    chk("flag cleared", 16'h0000, {d, 7'h00, irq});
  endtask
  task automatic abort_conv;
    logic [7:0] hi;
    wr(`OFS_CTRL_SECOND, 8'h40);
    wr(`OFS_CTRL_FIRST, 8'h9c);
    repeat (2) @(negedge ref_clk);
    chk("unpowered core", 16'h0000, 16'(conv_power_on));
    chk("unpowered start", 16'h0000, 16'(sample_start));
    wr(`OFS_CTRL_FIRST, 8'h9d);
    // Past the first bit period, so the abort lands inside the bit conversion
    repeat (200) @(posedge ref_clk);
    wr(`OFS_CTRL_FIRST, 8'h99);
    repeat (900) @(posedge ref_clk);
    rd(`OFS_RESULT_HIGH, hi);
    rd(`OFS_RESULT_LOW, d);
    chk("kept result", {prev_hi, prev_lo}, {hi, d});
    rd(`OFS_IRQ_STATUS, d);
    chk("no flag", 16'h0000, 16'(d));
  endtask
  task automatic reset_mid;
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("reset map again", 16'hff20, {pin_analog, vref_pos_pin, vref_neg_pin, analog_count, vref_count});
    @(posedge ref_clk);
    resetn <= 1'b1;
    rd(`OFS_CTRL_SECOND, d);
    chk("ctrl second reset", 16'h0000, {8'h00, d});
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    regs_and_decode();
    reset_mid();
    for (int i = 0; i < 8; i++) conv(i);
    abort_conv();
    test_done();
  end
endmodule
